// file: src/vrs_pkg.sv
// shared constants for the video receiver sideband block
package vrs_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int HPD_WAIT_MS = 1000;
   localparam longint HPD_WAIT_CYC_L = (longint'(CLK_HZ) / 1000) * HPD_WAIT_MS;
   localparam int HPD_WAIT_CYC = int'(HPD_WAIT_CYC_L);
   localparam int MGMT_AW = 8;
   localparam int MGMT_DW = 8;
   localparam int AUX_DW = 72;
   localparam int PKT_AW = 7;
   localparam int ACR_W = 20;
   localparam int GCP_W = 6;
   localparam int AVI_W_FRL = 123;
   localparam int AVI_W_STD = 112;
   localparam int VSI_W = 61;
   localparam int AUD_DW = 256;
   localparam int AUD_MW = 165;
   localparam int FMT_W = 5;
   localparam int FMT_3D_FIRST = 4;
   localparam int FIFO_DEPTH = 8;
   // management register indices
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_SCRATCH = 8'h01;
   localparam logic [7:0] REG_GCP = 8'h02;
   localparam logic [7:0] REG_FMT = 8'h03;
   localparam logic [7:0] REG_CRC_ERRS = 8'h04;
   localparam logic [7:0] SCRATCH_RST = 8'h00;
   typedef enum logic [1:0] {VRS_IDLE, VRS_PKT} vrs_pkt_state_t;
endpackage

// file: src/vrs_fifo.sv
// small valid/ready word buffer
`timescale 1ns/1ps
module vrs_fifo
   import vrs_pkg::*;
#(
   parameter int WIDTH = 74,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q, rd_q;
   logic push, pop;
   assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // head entry read straight from the array, no extra latency
   assign out_data = mem_q[rd_q[AW-1:0]];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
      end
   end
endmodule // vrs_fifo

// file: src/vrs_sideband.sv
// sideband outputs: hot-plug, ratio flag, management port, aux stream, audio
`timescale 1ns/1ps
// Functional notes
// R1 - hot-plug low without power or reset
// R2 - hot-plug high after one second power
// R3 - ratio flag one for ratio forty
// R4 - management port eight-bit address and read
// R5 - controller writes with strobe, address, data
// R6 - aux words qualified by valid
// R7 - start and end flags mark packets
// R8 - error flag on packet CRC failure
// R9 - aux and audio outputs need options
// R10 - packets written to external buffer
// R11 - twenty-bit cycle count and divider outputs
// R12 - six-bit general control bundle output
// R13 - infoframe width depends on fixed-rate support
// R14 - format bit four flags first eight
// R15 - read data one cycle after strobe
module vrs_sideband
   import vrs_pkg::*;
#(
   parameter bit SUPPORT_AUX = 1'b1,
   parameter bit SUPPORT_AUDIO = 1'b1,
   parameter bit SUPPORT_FRL = 1'b0,
   parameter int HPD_CYCLES = HPD_WAIT_CYC,
   parameter int FIFO_D = FIFO_DEPTH,
   localparam int AVI_W = SUPPORT_FRL ? AVI_W_FRL : AVI_W_STD
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESETN,
   // cable and link status
   input wire logic CABLE_POWER_SENSE,
   input wire logic HIGH_RATIO_LINK,
   input wire logic FRL_MODE,
   output logic HOTPLUG_REQ,
   output logic BIT_CLOCK_RATIO_FLAG,
   // management port
   input wire logic [MGMT_AW-1:0] MGMT_ADDR,
   input wire logic MGMT_RD,
   input wire logic MGMT_WR,
   input wire logic [MGMT_DW-1:0] MGMT_WDATA,
   output logic [MGMT_DW-1:0] MGMT_RDATA,
   // decoded packet words from the receiver core
   input wire logic RX_VALID,
   output logic RX_READY,
   input wire logic [AUX_DW-1:0] RX_DATA,
   input wire logic RX_SOP,
   input wire logic RX_EOP,
   input wire logic RX_CRC_BAD,
   // auxiliary stream
   output logic AUX_VALID,
   input wire logic AUX_READY,
   output logic [AUX_DW-1:0] AUX_DATA,
   output logic AUX_SOP,
   output logic AUX_EOP,
   output logic AUX_ERROR,
   // packet buffer write port
   output logic [PKT_AW-1:0] PKT_ADDR,
   output logic [AUX_DW-1:0] PKT_DATA,
   output logic PKT_WR,
   // decoded status bundles
   input wire logic [GCP_W-1:0] RX_GCP,
   input wire logic [AVI_W-1:0] RX_AVI,
   input wire logic [VSI_W-1:0] RX_VSI,
   output logic [GCP_W-1:0] GCP,
   output logic [AVI_W-1:0] INFO_AVI,
   output logic [VSI_W-1:0] INFO_VSI,
   // audio
   input wire logic [ACR_W-1:0] RX_CTS,
   input wire logic [ACR_W-1:0] RX_N,
   input wire logic RX_SAMPLE_VALID,
   input wire logic [AUD_DW-1:0] RX_AUDIO,
   input wire logic [AUD_MW-1:0] RX_AUDIO_META,
   input wire logic [FMT_W-1:0] RX_AUDIO_FMT,
   input wire logic RX_3D_FIRST8,
   output logic [ACR_W-1:0] AUDIO_CTS,
   output logic [ACR_W-1:0] AUDIO_N,
   output logic [AUD_DW-1:0] AUDIO_DATA,
   output logic SAMPLE_VALID,
   output logic [AUD_MW-1:0] AUDIO_META,
   output logic [FMT_W-1:0] AUDIO_FORMAT
);
   localparam int HPD_CW = $clog2(HPD_CYCLES + 1);
   localparam int FW = AUX_DW + 3;
   // elaboration checks refuse settings the logic cannot serve
   if (HPD_CYCLES < 1) begin : g_bad_wait
      $error("hot-plug wait must be at least one cycle");
   end
   if (SUPPORT_AUDIO && !SUPPORT_AUX) begin : g_bad_audio
      $error("audio needs aux support");
   end

   // reset release through two flops
   logic rst_s1_q, rst_n_q;
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // cable power sense: three flops, change accepted when last two agree
   logic [2:0] pwr_sync_q;
   logic pwr_q;
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pwr_sync_q <= 3'h0;
         pwr_q <= 1'b0;
      end else begin
         pwr_sync_q <= {pwr_sync_q[1:0], CABLE_POWER_SENSE};
         if (pwr_sync_q[1] == pwr_sync_q[2]) pwr_q <= pwr_sync_q[2];
      end
   end

   // hot-plug timer; counts only while power is seen
   // power loss wins over the timer, so a dip restarts the full wait
   logic [HPD_CW-1:0] hpd_cnt_q;
   logic hpd_q;
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hpd_cnt_q <= '0;
         hpd_q <= 1'b0;
      end else if (!pwr_q) begin
         // R1 drop on power loss
         hpd_cnt_q <= '0;
         hpd_q <= 1'b0;
      end else if (hpd_cnt_q == HPD_CW'(HPD_CYCLES - 1)) begin
         // R2 raise after wait
         hpd_q <= 1'b1;
      end else begin
         hpd_cnt_q <= hpd_cnt_q + 1'b1;
      end
   end
   assign HOTPLUG_REQ = hpd_q;

   // R3 ratio forty flag, zero in fixed-rate mode
   // both link pins cross domains: three flops each, change taken when last two agree
   logic [2:0] ratio_sync_q;
   logic [2:0] frl_sync_q;
   logic ratio_st_q;
   logic frl_st_q;
   logic ratio_st_d;
   logic frl_st_d;
   logic ratio_q;
   always_comb begin
      ratio_st_d = ratio_st_q;
      frl_st_d = frl_st_q;
      if (ratio_sync_q[1] == ratio_sync_q[2]) ratio_st_d = ratio_sync_q[2];
      if (frl_sync_q[1] == frl_sync_q[2]) frl_st_d = frl_sync_q[2];
   end
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ratio_sync_q <= 3'h0;
         frl_sync_q <= 3'h0;
         ratio_st_q <= 1'b0;
         frl_st_q <= 1'b0;
         ratio_q <= 1'b0;
      end else begin
         ratio_sync_q <= {ratio_sync_q[1:0], HIGH_RATIO_LINK};
         frl_sync_q <= {frl_sync_q[1:0], FRL_MODE};
         ratio_st_q <= ratio_st_d;
         frl_st_q <= frl_st_d;
         // flag follows the agreed values, same lag as power sense
         ratio_q <= ratio_st_d && !frl_st_d;
      end
   end
   assign BIT_CLOCK_RATIO_FLAG = ratio_q;

   // management registers
   logic [MGMT_DW-1:0] scratch_q;
   logic [MGMT_DW-1:0] rdata_q;
   logic [MGMT_DW-1:0] crc_errs_q;
   logic [FMT_W-1:0] fmt_q;
   logic [GCP_W-1:0] gcp_q;
   // R5 write taken on strobe
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         scratch_q <= SCRATCH_RST;
      end else if (MGMT_WR && MGMT_ADDR == REG_SCRATCH) begin
         scratch_q <= MGMT_WDATA;
      end
   end
   // reads have no side effects, so polling is safe
   // R4 R15 read one cycle after strobe
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= '0;
      end else if (MGMT_RD) begin
         case (MGMT_ADDR)
            REG_STATUS: rdata_q <= {5'h00, ratio_q, pwr_q, hpd_q};
            REG_SCRATCH: rdata_q <= scratch_q;
            REG_GCP: rdata_q <= {2'h0, gcp_q};
            REG_FMT: rdata_q <= {3'h0, fmt_q};
            REG_CRC_ERRS: rdata_q <= crc_errs_q;
            default: rdata_q <= 8'h00;
         endcase
      end
   end
   assign MGMT_RDATA = rdata_q;

   // aux stream through the buffer so the consumer can stall
   // eight words absorb a short consumer stall without losing input
   logic fifo_out_valid;
   logic [FW-1:0] fifo_out;
   logic fifo_in_ready;
   logic pkt_wr_q;
   logic aux_ready_eff;
   assign aux_ready_eff = SUPPORT_AUX ? AUX_READY : 1'b1;
   assign RX_READY = fifo_in_ready;

   vrs_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_D)
   ) u_fifo (
      .clk(CLK_SYS),
      .rst_n(rst_n_q),
      .in_valid(RX_VALID),
      .in_ready(fifo_in_ready),
      .in_data({RX_SOP, RX_EOP, RX_CRC_BAD, RX_DATA}),
      .out_valid(fifo_out_valid),
      .out_ready(aux_ready_eff),
      .out_data(fifo_out)
   );

   logic take;
   assign take = fifo_out_valid && aux_ready_eff;

   // R9 stream only with aux support
   // R6 word qualified by valid
   assign AUX_VALID = SUPPORT_AUX && fifo_out_valid;
   assign AUX_DATA = SUPPORT_AUX ? fifo_out[AUX_DW-1:0] : '0;
   // R7 packet boundary flags
   assign AUX_SOP = SUPPORT_AUX && fifo_out_valid && fifo_out[FW-1];
   assign AUX_EOP = SUPPORT_AUX && fifo_out_valid && fifo_out[FW-2];
   // R8 crc failure marked on the word
   assign AUX_ERROR = SUPPORT_AUX && fifo_out_valid && fifo_out[FW-3];

   // error counter saturates rather than wraps
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         crc_errs_q <= '0;
      end else if (take && fifo_out[FW-3] && crc_errs_q != 8'hff) begin
         crc_errs_q <= crc_errs_q + 1'b1;
      end
   end

   // R10 packet buffer writes, address restarts at packet start
   // a word without a start flag keeps counting from the last address
   logic [PKT_AW-1:0] pkt_addr_q;
   logic [AUX_DW-1:0] pkt_data_q;
   vrs_pkt_state_t pst_q;
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pkt_addr_q <= '0;
         pkt_data_q <= '0;
         pkt_wr_q <= 1'b0;
         pst_q <= VRS_IDLE;
      end else begin
         pkt_wr_q <= SUPPORT_AUX && take;
         if (take) begin
            pkt_data_q <= fifo_out[AUX_DW-1:0];
            case (pst_q)
               VRS_IDLE: pkt_addr_q <= fifo_out[FW-1] ? '0 : pkt_addr_q + 1'b1;
               VRS_PKT: pkt_addr_q <= fifo_out[FW-1] ? '0 : pkt_addr_q + 1'b1;
               default: pkt_addr_q <= '0;
            endcase
            pst_q <= fifo_out[FW-2] ? VRS_IDLE : VRS_PKT;
         end
      end
   end
   assign PKT_ADDR = pkt_addr_q;
   assign PKT_DATA = pkt_data_q;
   assign PKT_WR = pkt_wr_q;

   // status bundles registered
   logic [AVI_W-1:0] avi_q;
   logic [VSI_W-1:0] vsi_q;
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         gcp_q <= '0;
         avi_q <= '0;
         vsi_q <= '0;
      end else if (SUPPORT_AUX) begin
         // R12 control bundle
         gcp_q <= RX_GCP;
         // R13 width set by fixed-rate option
         avi_q <= RX_AVI;
         vsi_q <= RX_VSI;
      end
   end
   assign GCP = gcp_q;
   assign INFO_AVI = avi_q;
   assign INFO_VSI = vsi_q;

   // audio outputs
   logic [ACR_W-1:0] cts_q, n_q;
   logic [AUD_DW-1:0] aud_q;
   logic [AUD_MW-1:0] meta_q;
   logic sv_q;
   // R9 audio needs both options
   // R11 twenty-bit regeneration values
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cts_q <= '0;
         n_q <= '0;
      end else if (SUPPORT_AUX && SUPPORT_AUDIO) begin
         cts_q <= RX_CTS;
         n_q <= RX_N;
      end
   end
   // samples held between valid strobes
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         aud_q <= '0;
         meta_q <= '0;
         sv_q <= 1'b0;
      end else if (SUPPORT_AUX && SUPPORT_AUDIO) begin
         sv_q <= RX_SAMPLE_VALID;
         if (RX_SAMPLE_VALID) aud_q <= RX_AUDIO;
         meta_q <= RX_AUDIO_META;
      end
   end
   // R14 first eight of 3d sample
   // the 3d marker overrides bit four of the raw format
   always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fmt_q <= '0;
      end else if (SUPPORT_AUX && SUPPORT_AUDIO) begin
         fmt_q <= RX_AUDIO_FMT;
         fmt_q[FMT_3D_FIRST] <= RX_3D_FIRST8;
      end
   end
   assign AUDIO_CTS = cts_q;
   assign AUDIO_N = n_q;
   assign AUDIO_DATA = aud_q;
   assign SAMPLE_VALID = sv_q;
   assign AUDIO_META = meta_q;
   assign AUDIO_FORMAT = fmt_q;
endmodule // vrs_sideband

// file: tb/vrs_sideband_props.sv
// concurrent checks on the sideband block ports
`timescale 1ns/1ps
module vrs_sideband_props
   import vrs_pkg::*;
#(
   parameter int HPD_CYCLES = 20
) (
   // clock, reset, cable and link
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CABLE_POWER_SENSE,
   input wire logic HIGH_RATIO_LINK,
   input wire logic FRL_MODE,
   input wire logic HOTPLUG_REQ,
   input wire logic BIT_CLOCK_RATIO_FLAG,
   // management
   input wire logic [7:0] MGMT_ADDR,
   input wire logic MGMT_RD,
   input wire logic MGMT_WR,
   input wire logic [7:0] MGMT_WDATA,
   input wire logic [7:0] MGMT_RDATA,
   // aux stream and packet buffer
   input wire logic AUX_VALID,
   input wire logic AUX_READY,
   input wire logic [71:0] AUX_DATA,
   input wire logic AUX_SOP,
   input wire logic [6:0] PKT_ADDR,
   input wire logic PKT_WR
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   logic [1:0] up_q;
   int pwr_q;
   // internal reset lags the pin by two flops
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) pwr_q <= 0;
      else if (!CABLE_POWER_SENSE) pwr_q <= 0;
      else if (pwr_q < HPD_CYCLES + 12) pwr_q <= pwr_q + 1;
   end
   a_hpd_drop: assert property (!CABLE_POWER_SENSE [*6] |-> !HOTPLUG_REQ)
      else $error("hot-plug high without power");
   a_hpd_early: assert property ($rose(HOTPLUG_REQ) |-> pwr_q >= HPD_CYCLES)
      else $error("hot-plug rose too early");
   a_hpd_late: assert property (pwr_q == HPD_CYCLES + 12 |-> HOTPLUG_REQ)
      else $error("hot-plug did not rise");
   a_ratio_frl: assert property (FRL_MODE [*5] |-> !BIT_CLOCK_RATIO_FLAG)
      else $error("ratio flag set in fixed-rate mode");
   a_ratio_high: assert property ((up_q == 2'h3 && HIGH_RATIO_LINK && !FRL_MODE) [*5] |-> BIT_CLOCK_RATIO_FLAG)
      else $error("ratio flag not set");
   a_scratch_read: assert property (MGMT_WR && MGMT_ADDR == REG_SCRATCH ##1 MGMT_RD && !MGMT_WR
      && MGMT_ADDR == REG_SCRATCH |=> MGMT_RDATA == $past(MGMT_WDATA, 2))
      else $error("scratch read-back wrong");
   a_rdata_hold: assert property (!MGMT_RD |=> $stable(MGMT_RDATA))
      else $error("read data changed without read");
   a_aux_hold: assert property (AUX_VALID && !AUX_READY |=> AUX_VALID && $stable(AUX_DATA) && $stable(AUX_SOP))
      else $error("aux word dropped while stalled");
   a_pkt_write: assert property (AUX_VALID && AUX_READY |=> PKT_WR)
      else $error("packet write missing");
   a_pkt_sop: assert property (AUX_VALID && AUX_READY && AUX_SOP |=> PKT_ADDR == 7'h00)
      else $error("packet start address wrong");
endmodule // vrs_sideband_props

// file: tb/vrs_aux_sink.sv
// aux stream consumer that stalls when told
`timescale 1ns/1ps
module vrs_aux_sink (
   // clock and commanded stall
   input wire logic clk,
   input wire logic stall,
   // aux stream
   input wire logic valid,
   input wire logic [71:0] data,
   input wire logic sop,
   input wire logic eop,
   input wire logic err,
   output logic ready
);
   logic [74:0] got[$];
   initial ready = 1'b0;
   always @(negedge clk) ready <= !stall;
   always @(posedge clk) if (valid && ready) got.push_back({err, eop, sop, data});
endmodule // vrs_aux_sink

// file: tb/vrs_sideband_tb_top.sv
// self-checking bench for the sideband block
`timescale 1ns/1ps
module vrs_sideband_tb_top;
   import vrs_pkg::*;
   logic CLK_SYS = 1'b0, RESETN = 1'b0, CABLE_POWER_SENSE = 1'b0, HIGH_RATIO_LINK = 1'b0, FRL_MODE = 1'b0;
   logic MGMT_RD = 1'b0, MGMT_WR = 1'b0, RX_VALID = 1'b0, RX_SOP = 1'b0, RX_EOP = 1'b0, RX_CRC_BAD = 1'b0;
   logic RX_SAMPLE_VALID = 1'b0, RX_3D_FIRST8 = 1'b0, stall = 1'b1;
   logic [7:0] MGMT_ADDR = 8'h00, MGMT_WDATA = 8'h00;
   logic [71:0] RX_DATA = 72'h0;
   logic [5:0] RX_GCP = 6'h00;
   logic [111:0] RX_AVI = 112'h0;
   logic [60:0] RX_VSI = 61'h0;
   logic [19:0] RX_CTS = 20'h0, RX_N = 20'h0;
   logic [255:0] RX_AUDIO = 256'h0;
   logic [164:0] RX_AUDIO_META = 165'h0;
   logic [4:0] RX_AUDIO_FMT = 5'h00;
   wire HOTPLUG_REQ, BIT_CLOCK_RATIO_FLAG, RX_READY, AUX_VALID, AUX_READY, AUX_SOP, AUX_EOP, AUX_ERROR;
   wire PKT_WR, SAMPLE_VALID;
   wire [7:0] MGMT_RDATA;
   wire [71:0] AUX_DATA, PKT_DATA;
   wire [6:0] PKT_ADDR;
   wire [5:0] GCP;
   wire [111:0] INFO_AVI;
   wire [60:0] INFO_VSI;
   wire [19:0] AUDIO_CTS, AUDIO_N;
   wire [255:0] AUDIO_DATA;
   wire [164:0] AUDIO_META;
   wire [4:0] AUDIO_FORMAT;
   int num_errors = 0;
   int checks_done = 0;
   always #2.5 CLK_SYS = ~CLK_SYS;
   // short hot-plug wait keeps the run brief
   vrs_sideband #(.HPD_CYCLES(20)) vrs_sideband_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
      .CABLE_POWER_SENSE(CABLE_POWER_SENSE), .HIGH_RATIO_LINK(HIGH_RATIO_LINK), .FRL_MODE(FRL_MODE),
      .HOTPLUG_REQ(HOTPLUG_REQ), .BIT_CLOCK_RATIO_FLAG(BIT_CLOCK_RATIO_FLAG), .MGMT_ADDR(MGMT_ADDR),
      .MGMT_RD(MGMT_RD), .MGMT_WR(MGMT_WR), .MGMT_WDATA(MGMT_WDATA), .MGMT_RDATA(MGMT_RDATA),
      .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_DATA(RX_DATA), .RX_SOP(RX_SOP), .RX_EOP(RX_EOP),
      .RX_CRC_BAD(RX_CRC_BAD), .AUX_VALID(AUX_VALID), .AUX_READY(AUX_READY), .AUX_DATA(AUX_DATA),
      .AUX_SOP(AUX_SOP), .AUX_EOP(AUX_EOP), .AUX_ERROR(AUX_ERROR), .PKT_ADDR(PKT_ADDR), .PKT_DATA(PKT_DATA),
      .PKT_WR(PKT_WR), .RX_GCP(RX_GCP), .RX_AVI(RX_AVI), .RX_VSI(RX_VSI), .GCP(GCP), .INFO_AVI(INFO_AVI),
      .INFO_VSI(INFO_VSI), .RX_CTS(RX_CTS), .RX_N(RX_N), .RX_SAMPLE_VALID(RX_SAMPLE_VALID),
      .RX_AUDIO(RX_AUDIO), .RX_AUDIO_META(RX_AUDIO_META), .RX_AUDIO_FMT(RX_AUDIO_FMT),
      .RX_3D_FIRST8(RX_3D_FIRST8), .AUDIO_CTS(AUDIO_CTS), .AUDIO_N(AUDIO_N), .AUDIO_DATA(AUDIO_DATA),
      .SAMPLE_VALID(SAMPLE_VALID), .AUDIO_META(AUDIO_META), .AUDIO_FORMAT(AUDIO_FORMAT));
   vrs_aux_sink vrs_aux_sink_inst (.clk(CLK_SYS), .stall(stall), .valid(AUX_VALID), .data(AUX_DATA),
      .sop(AUX_SOP), .eop(AUX_EOP), .err(AUX_ERROR), .ready(AUX_READY));
   task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // called at a falling edge, returns at the next one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      MGMT_ADDR = a;
      MGMT_WDATA = d;
      MGMT_WR = 1'b1;
      @(negedge CLK_SYS);
      MGMT_WR = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      MGMT_ADDR = a;
      MGMT_RD = 1'b1;
      @(negedge CLK_SYS);
      MGMT_RD = 1'b0;
      chk("mgmt_rdata", MGMT_RDATA, exp);
   endtask
   task automatic send(input logic [71:0] d, input logic s, input logic e, input logic b);
      RX_VALID = 1'b1;
      RX_DATA = d;
      RX_SOP = s;
      RX_EOP = e;
      RX_CRC_BAD = b;
      for (int i = 0; i < 60 && RX_READY !== 1'b1; i++) @(negedge CLK_SYS);
      @(negedge CLK_SYS);
   endtask
   initial begin
      repeat (12) @(negedge CLK_SYS);
      RESETN = 1'b1;
      repeat (4) @(negedge CLK_SYS);
      chk("hotplug", HOTPLUG_REQ, 1'b0);
      CABLE_POWER_SENSE = 1'b1;
      repeat (18) @(negedge CLK_SYS);
      chk("hotplug", HOTPLUG_REQ, 1'b0);
      repeat (14) @(negedge CLK_SYS);
      chk("hotplug", HOTPLUG_REQ, 1'b1);
      rd(REG_STATUS, 8'h03);
      HIGH_RATIO_LINK = 1'b1;
      repeat (6) @(negedge CLK_SYS);
      chk("ratio", BIT_CLOCK_RATIO_FLAG, 1'b1);
      FRL_MODE = 1'b1;
      repeat (6) @(negedge CLK_SYS);
      chk("ratio", BIT_CLOCK_RATIO_FLAG, 1'b0);
      CABLE_POWER_SENSE = 1'b0;
      repeat (6) @(negedge CLK_SYS);
      chk("hotplug", HOTPLUG_REQ, 1'b0);
      wr(REG_SCRATCH, 8'ha5);
      rd(REG_SCRATCH, 8'ha5);
      wr(REG_STATUS, 8'hff);
      rd(8'h10, 8'h00);
      // eight words fill the buffer, which must then hold ready low
      for (int i = 0; i < 8; i++) send(72'h1200 + 72'(i), i == 0, i == 7, 1'b0);
      RX_VALID = 1'b0;
      chk("rx_ready", RX_READY, 1'b0);
      stall = 1'b0;
      repeat (12) @(negedge CLK_SYS);
      chk("aux_count", vrs_aux_sink_inst.got.size(), 8);
      for (int i = 0; i < 8; i++) chk("aux_word", vrs_aux_sink_inst.got[i], {1'b0, i == 7, i == 0, 72'h1200 + 72'(i)});
      chk("pkt_addr", PKT_ADDR, 7'h07);
      send(72'hbad, 1'b1, 1'b1, 1'b1);
      RX_VALID = 1'b0;
      repeat (4) @(negedge CLK_SYS);
      chk("aux_err", vrs_aux_sink_inst.got[8], {3'b111, 72'hbad});
      chk("pkt_addr", PKT_ADDR, 7'h00);
      chk("pkt_data", PKT_DATA, 72'hbad);
      rd(REG_CRC_ERRS, 8'h01);
      RX_GCP = 6'h2a;
      RX_CTS = 20'habcde;
      RX_N = 20'h01800;
      RX_3D_FIRST8 = 1'b1;
      RX_SAMPLE_VALID = 1'b1;
      RX_AUDIO = 256'h55;
      RX_AVI = {112{1'b1}};
      RX_VSI = 61'h1234;
      RX_AUDIO_META = 165'h3c;
      RX_AUDIO_FMT = 5'h03;
      repeat (2) @(negedge CLK_SYS);
      chk("gcp", GCP, 6'h2a);
      chk("cts", AUDIO_CTS, 20'habcde);
      chk("n", AUDIO_N, 20'h01800);
      chk("fmt_first8", AUDIO_FORMAT[FMT_3D_FIRST], 1'b1);
      chk("sample", {SAMPLE_VALID, AUDIO_DATA[7:0]}, 9'h155);
      chk("avi", INFO_AVI, {112{1'b1}});
      chk("vsi", INFO_VSI, 61'h1234);
      chk("meta", AUDIO_META, 165'h3c);
      chk("fmt", AUDIO_FORMAT, 5'h13);
      rd(REG_GCP, 8'h2a);
      rd(REG_FMT, 8'h13);
      RX_SAMPLE_VALID = 1'b0;
      RX_AUDIO = 256'haa;
      repeat (2) @(negedge CLK_SYS);
      chk("sample_hold", {SAMPLE_VALID, AUDIO_DATA[7:0]}, 9'h055);
      complete_run();
   end
   initial begin
      repeat (3000) @(posedge CLK_SYS);
      num_errors++;
      complete_run();
   end
endmodule // vrs_sideband_tb_top
bind vrs_sideband vrs_sideband_props #(.HPD_CYCLES(HPD_CYCLES)) vrs_sideband_props_inst (.CLK_SYS(CLK_SYS),
   .RESETN(RESETN), .CABLE_POWER_SENSE(CABLE_POWER_SENSE), .HIGH_RATIO_LINK(HIGH_RATIO_LINK),
   .FRL_MODE(FRL_MODE), .HOTPLUG_REQ(HOTPLUG_REQ), .BIT_CLOCK_RATIO_FLAG(BIT_CLOCK_RATIO_FLAG),
   .MGMT_ADDR(MGMT_ADDR), .MGMT_RD(MGMT_RD), .MGMT_WR(MGMT_WR), .MGMT_WDATA(MGMT_WDATA),
   .MGMT_RDATA(MGMT_RDATA), .AUX_VALID(AUX_VALID), .AUX_READY(AUX_READY), .AUX_DATA(AUX_DATA),
   .AUX_SOP(AUX_SOP), .PKT_ADDR(PKT_ADDR), .PKT_WR(PKT_WR));
